// File: meas_status_pkg.sv
// Package: offsets, field positions, reset values for measurement status
package meas_status_pkg;
   // ---------------------------------------------------------------
   // Register map (printed offset 0x01 is a register index)
   // ---------------------------------------------------------------
   localparam logic [3:0]  STATUS_INDEX      = 4'h1;
   localparam logic [3:0]  IRQ_STATUS_INDEX  = 4'h2;
   localparam logic [3:0]  IRQ_MASK_INDEX    = 4'h3;
   localparam logic [3:0]  CONV_CTRL_INDEX   = 4'h4;
   localparam int          ADDR_W            = 6;
   localparam logic [5:0]  STATUS_ADDR       = {STATUS_INDEX, 2'b00};
   localparam logic [5:0]  IRQ_STATUS_ADDR   = {IRQ_STATUS_INDEX, 2'b00};
   localparam logic [5:0]  IRQ_MASK_ADDR     = {IRQ_MASK_INDEX, 2'b00};
   localparam logic [5:0]  CONV_CTRL_ADDR    = {CONV_CTRL_INDEX, 2'b00};
   // ---------------------------------------------------------------
   // Status word fields
   // ---------------------------------------------------------------
   localparam int          PIN_FN_HI   = 15;
   localparam int          PIN_FN_LO   = 14;
   localparam int          SLEEP_BIT   = 13;
   localparam int          GLOBAL_BIT  = 11;
   localparam int          BATTERY_INPUT_ONE_BIT    = 6;
   localparam int          BATTERY_INPUT_TWO_BIT    = 5;
   localparam int          AUX_BIT     = 4;
   localparam int          THERMAL_INPUT_ONE_BIT   = 2;
   localparam int          THERMAL_INPUT_TWO_BIT   = 1;
   localparam logic [1:0]  PIN_FN_RESET = 2'h2;
   localparam logic [1:0]  PIN_FN_DONE  = 2'h1;
   localparam logic [3:0]  SCAN_PORT    = 4'hb;
   localparam logic [4:0]  FRESH_NONE   = 5'h00;
   // Channel index in the five-bit fresh vector
   localparam int          CH_BATTERY_INPUT_ONE  = 4;
   localparam int          CH_BATTERY_INPUT_TWO  = 3;
   localparam int          CH_AUX   = 2;
   localparam int          CH_THERMAL_INPUT_ONE = 1;
   localparam int          CH_THERMAL_INPUT_TWO = 0;
   // Interrupt events
   localparam int          IRQ_DONE_BIT  = 0;
   localparam int          IRQ_SLEEP_BIT = 1;
   localparam logic [1:0]  IRQ_NONE      = 2'h0;
   localparam logic [31:0] WORD_ZERO     = 32'h0000_0000;
   localparam logic [15:0] HALF_ZERO     = 16'h0000;
endpackage

// File: meas_fresh_if.sv
// Interface: per-channel fresh flags between tracker and status bank
`timescale 1ns/10ps
interface meas_fresh_if;
   logic [4:0] load;
   logic [4:0] drained;
   logic       set_done;
   logic [4:0] fresh;
   logic       global_ready;
   modport tracker (input load, input drained, input set_done,
                    output fresh, output global_ready);
   modport bank    (output load, output drained, output set_done,
                    input fresh, input global_ready);
endinterface

// File: meas_fresh_tracker.sv
// Fresh-data flags per channel and global data-ready flag
`timescale 1ns/10ps
module meas_fresh_tracker
   import meas_status_pkg::*;
(
   input  wire logic clock_i,
   input  wire logic rstn_i,
   meas_fresh_if.tracker fl
);
   logic [4:0] fresh_reg;
   logic       global_reg;

   // Load wins over readout in the same cycle
   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         fresh_reg <= FRESH_NONE;
      end else begin
         fresh_reg <= fl.load | (fresh_reg & ~fl.drained);
      end
   end

   // Global flag clears only once nothing is pending
   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         global_reg <= 1'b0;
      end else if (fl.set_done) begin
         global_reg <= 1'b1;
      end else if ((fresh_reg & ~fl.drained) == FRESH_NONE
                   && fl.load == FRESH_NONE) begin
         global_reg <= 1'b0;
      end
   end

   assign fl.fresh        = fresh_reg;
   assign fl.global_ready = global_reg;
endmodule // meas_fresh_tracker

// File: meas_adc_status_flags.sv
// Measurement converter status register bank with Avalon-MM slave
//
// Register access over Avalon-MM was left to the implementer.
`timescale 1ns/10ps
// Contract
// - Bits 15:14 select pin function, reset 10; only 01 means done.
// - With function 01, done pin drops when a conversion set finishes.
// - In scan mode the pin stays low until all scan results read.
// - Bit 13 reads 1 when converter is powered down, else 0.
// - Bit 11 sets when one set of conversions completes.
// - Bit 11 clears only after all pending data has been read.
// - Bit 6 flags fresh battery one data until read out.
// - Bit 5 flags fresh battery two data until read out.
// - Bit 4 flags fresh extra input data until read out.
// - Bit 2 flags fresh thermal one data until read out.
// - Bit 1 flags fresh thermal two data until read out.
// - Scan code 1011 converts both batteries and extra input in turn.
module meas_adc_status_flags
   import meas_status_pkg::*;
(
   input  wire logic              clock_i,
   input  wire logic              rstn_i,
   // Avalon-MM slave
   input  wire logic [ADDR_W-1:0] address_i,
   input  wire logic              read_i,
   input  wire logic              write_i,
   input  wire logic [31:0]       writedata_i,
   input  wire logic [3:0]        byteenable_i,
   output logic [31:0]            readdata_o,
   output logic                   waitrequest_o,
   output logic [1:0]             response_o,
   // Converter core side
   input  wire logic              conv_busy_i,
   input  wire logic              conv_sleep_i,
   input  wire logic              result_load_i,
   input  wire logic [4:0]        result_chan_i,
   input  wire logic              set_done_i,
   input  wire logic [4:0]        result_drained_i,
   // Pins and events
   output logic                   conversion_done_pin_n_o,
   output logic [3:0]             scan_mode_o,
   output logic                   irq_o
);
   // ---------------------------------------------------------------
   // Types and state
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {BUS_IDLE, BUS_ANSWER} bus_state_t;

   bus_state_t  bus_reg;
   bus_state_t  bus_next;
   logic [1:0]  pin_fn_reg;
   logic [3:0]  scan_mode_reg;
   logic        sleep_reg;
   logic        sleep_prev_reg;
   logic        done_pin_n_reg;
   logic [1:0]  irq_status_reg;
   logic [1:0]  irq_mask_reg;
   logic        irq_reg;
   logic [31:0] readdata_reg;
   logic [1:0]  response_reg;
   logic        accept;
   logic        wr_hit;
   logic [1:0]  irq_event;
   logic        scan_pending;
   logic [15:0] status_word;

   meas_fresh_if fl ();

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   function automatic logic lane_low(input logic [3:0] be);
      lane_low = be[0] | be[1];
   endfunction

   function automatic logic known_addr(input logic [ADDR_W-1:0] a);
      known_addr = (a == STATUS_ADDR) || (a == IRQ_STATUS_ADDR) ||
                   (a == IRQ_MASK_ADDR) || (a == CONV_CTRL_ADDR);
   endfunction

   // ---------------------------------------------------------------
   // Fresh flag tracker
   // ---------------------------------------------------------------
   // Load and done strobes are same-domain converter logic
   assign fl.load     = result_load_i ? result_chan_i : FRESH_NONE;
   assign fl.drained  = result_drained_i;
   assign fl.set_done = set_done_i;

   meas_fresh_tracker u_tracker (
      .clock_i (clock_i),
      .rstn_i  (rstn_i),
      .fl      (fl)
   );

   // ---------------------------------------------------------------
   // Status word assembly
   // ---------------------------------------------------------------
   always_comb begin
      status_word = HALF_ZERO;
      status_word[PIN_FN_HI:PIN_FN_LO] = pin_fn_reg;
      status_word[SLEEP_BIT]  = sleep_reg;
      status_word[GLOBAL_BIT] = fl.global_ready;
      status_word[BATTERY_INPUT_ONE_BIT]   = fl.fresh[CH_BATTERY_INPUT_ONE];
      status_word[BATTERY_INPUT_TWO_BIT]   = fl.fresh[CH_BATTERY_INPUT_TWO];
      status_word[AUX_BIT]    = fl.fresh[CH_AUX];
      status_word[THERMAL_INPUT_ONE_BIT]  = fl.fresh[CH_THERMAL_INPUT_ONE];
      status_word[THERMAL_INPUT_TWO_BIT]  = fl.fresh[CH_THERMAL_INPUT_TWO];
   end

   // ---------------------------------------------------------------
   // Bus slave: one wait cycle, answer on the second edge
   // ---------------------------------------------------------------
   assign accept = (bus_reg == BUS_ANSWER);
   assign wr_hit = accept && write_i && lane_low(byteenable_i);

   always_comb begin
      bus_next = bus_reg;
      case (bus_reg)
         BUS_IDLE: begin
            if (read_i || write_i) begin
               bus_next = BUS_ANSWER;
            end
         end
         BUS_ANSWER: bus_next = BUS_IDLE;
         default:    bus_next = BUS_IDLE;
      endcase
   end

   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         bus_reg <= BUS_IDLE;
      end else begin
         bus_reg <= bus_next;
      end
   end

   // Waitrequest low only in the answer cycle
   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         waitrequest_o <= 1'b1;
      end else begin
         waitrequest_o <= !(bus_next == BUS_ANSWER);
      end
   end

   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         readdata_reg <= WORD_ZERO;
         response_reg <= 2'h0;
      end else if (bus_reg == BUS_IDLE && (read_i || write_i)) begin
         response_reg <= known_addr(address_i) ? 2'h0 : 2'h2;
         readdata_reg <= WORD_ZERO;
         if (read_i) begin
            case (address_i)
               STATUS_ADDR:     readdata_reg <= {HALF_ZERO, status_word};
               IRQ_STATUS_ADDR: readdata_reg <= {30'h0, irq_status_reg};
               IRQ_MASK_ADDR:   readdata_reg <= {30'h0, irq_mask_reg};
               CONV_CTRL_ADDR:  readdata_reg <= {28'h0, scan_mode_reg};
               default:         readdata_reg <= WORD_ZERO;
            endcase
         end
      end
   end

   // ---------------------------------------------------------------
   // Writable fields
   // ---------------------------------------------------------------
   // Only the pin-function field of the status word is writable; the rest of that word is read-only
   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         pin_fn_reg <= PIN_FN_RESET;
      end else if (wr_hit && address_i == STATUS_ADDR && byteenable_i[1]) begin
         pin_fn_reg <= writedata_i[PIN_FN_HI:PIN_FN_LO];
      end
   end

   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         scan_mode_reg <= 4'h0;
      end else if (wr_hit && address_i == CONV_CTRL_ADDR
                   && byteenable_i[0]) begin
         scan_mode_reg <= writedata_i[3:0];
      end
   end

   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         irq_mask_reg <= IRQ_NONE;
      end else if (wr_hit && address_i == IRQ_MASK_ADDR
                   && byteenable_i[0]) begin
         irq_mask_reg <= writedata_i[1:0];
      end
   end

   // ---------------------------------------------------------------
   // Converter state and done pin
   // ---------------------------------------------------------------
   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         sleep_reg      <= 1'b0;
         sleep_prev_reg <= 1'b0;
      end else begin
         sleep_reg      <= conv_sleep_i & ~conv_busy_i;
         sleep_prev_reg <= sleep_reg;
      end
   end

   // Scan code 1011 fills three registers; all must drain
   assign scan_pending = (scan_mode_reg == SCAN_PORT) ?
      |(fl.fresh & {1'b1, 1'b1, 1'b1, 1'b0, 1'b0}) : |fl.fresh;

   // Pin idles high; reserved codes never assert it (host sets 01)
   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         done_pin_n_reg <= 1'b1;
      end else if (pin_fn_reg != PIN_FN_DONE) begin
         done_pin_n_reg <= 1'b1;
      end else if (set_done_i) begin
         done_pin_n_reg <= 1'b0;
      end else if (!scan_pending && !fl.global_ready) begin
         done_pin_n_reg <= 1'b1;
      end
   end

   assign conversion_done_pin_n_o = done_pin_n_reg;

   // ---------------------------------------------------------------
   // Interrupts: sticky, write one to clear, set wins
   // ---------------------------------------------------------------
   assign irq_event[IRQ_DONE_BIT]  = set_done_i;
   assign irq_event[IRQ_SLEEP_BIT] = sleep_reg & ~sleep_prev_reg;

   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         irq_status_reg <= IRQ_NONE;
      end else if (wr_hit && address_i == IRQ_STATUS_ADDR
                   && byteenable_i[0]) begin
         irq_status_reg <= irq_event | (irq_status_reg & ~writedata_i[1:0]);
      end else begin
         irq_status_reg <= irq_event | irq_status_reg;
      end
   end

   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         irq_reg <= 1'b0;
      end else begin
         irq_reg <= |(irq_status_reg & irq_mask_reg);
      end
   end

   assign irq_o       = irq_reg;
   assign readdata_o  = readdata_reg;
   assign response_o  = response_reg;
   assign scan_mode_o = scan_mode_reg;
endmodule // meas_adc_status_flags

// File: meas_status_assertions.sv
// Concurrent checks on the measurement status bank ports
`timescale 1ns/10ps
module meas_status_assertions
   import meas_status_pkg::*;
(
   input  wire logic              clock_i,
   input  wire logic              rstn_i,
   input  wire logic [ADDR_W-1:0] address_i,
   input  wire logic              read_i,
   input  wire logic              write_i,
   input  wire logic [31:0]       readdata_o,
   input  wire logic              waitrequest_o,
   input  wire logic [1:0]        response_o,
   input  wire logic              result_load_i,
   input  wire logic              set_done_i,
   input  wire logic              conversion_done_pin_n_o
);
   // ---------------------------------------------------------------
   // Bus and pin relations
   // ---------------------------------------------------------------
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!rstn_i);
   logic mapped;
   assign mapped = address_i inside {STATUS_ADDR, IRQ_STATUS_ADDR,
                                     IRQ_MASK_ADDR, CONV_CTRL_ADDR};
   sequence s_taken;
      (read_i || write_i) && waitrequest_o;
   endsequence
   sequence s_answer;
      !waitrequest_o ##1 waitrequest_o;
   endsequence
   a_wait_answer: assert property (s_taken |=> s_answer)
      else $error("access not answered in one cycle");
   a_wait_idle: assert property (!(read_i || write_i) |=> waitrequest_o)
      else $error("answer without request");
   a_unmapped_resp: assert property ((s_taken and !mapped) |=>
      response_o == 2'h2 && readdata_o == WORD_ZERO)
      else $error("unmapped access not refused");
   a_mapped_ok: assert property ((s_taken and mapped) |=>
      response_o == 2'h0)
      else $error("mapped access refused");
   a_reserved_zero: assert property (!waitrequest_o && read_i &&
      address_i == STATUS_ADDR |-> (readdata_o & 32'hffff_1789) == 0)
      else $error("reserved status bits not zero");
   a_pin_falls_done: assert property ($fell(conversion_done_pin_n_o)
      |-> $past(set_done_i))
      else $error("done pin fell without a finished set");
   a_pin_holds_load: assert property (!conversion_done_pin_n_o &&
      result_load_i && !write_i |=> !conversion_done_pin_n_o)
      else $error("done pin released with fresh data");
   a_read_stands: assert property (!(read_i || write_i) |=>
      $stable(readdata_o))
      else $error("read data moved between accesses");
endmodule // meas_status_assertions

bind meas_adc_status_flags meas_status_assertions chk (.*);

// File: meas_host.sv
// Host model issuing Avalon-MM register accesses
`timescale 1ns/10ps
module meas_host
   import meas_status_pkg::*;
(
   input  wire logic              clock_i,
   input  wire logic              waitrequest_i,
   input  wire logic [31:0]       readdata_i,
   input  wire logic [1:0]        response_i,
   output logic [ADDR_W-1:0]      address_o,
   output logic                   read_o,
   output logic                   write_o,
   output logic [31:0]            writedata_o
);
   initial begin
      address_o   = '0;
      read_o      = 1'b0;
      write_o     = 1'b0;
      writedata_o = WORD_ZERO;
   end
   // Request held until the edge that sees waitrequest low
   task automatic access(input logic wr, input logic [ADDR_W-1:0] a,
                         input logic [31:0] wd, output logic [31:0] rd,
                         output logic [1:0] rsp, output bit ok);
      ok = 0;
      @(posedge clock_i);
      address_o   <= a;
      writedata_o <= wd;
      read_o      <= !wr;
      write_o     <= wr;
      // Sampled at the rising edge itself, before the slave updates
      for (int n = 0; n < 50 && !ok; n++) begin
         @(posedge clock_i);
         ok  = (waitrequest_i === 1'b0);
         rd  = readdata_i;
         rsp = response_i;
      end
      read_o  <= 1'b0;
      write_o <= 1'b0;
   endtask
endmodule // meas_host

// File: meas_adc_status_flags_bench.sv
// Self-checking bench for the measurement status bank
`timescale 1ns/10ps
module meas_adc_status_flags_bench
   import meas_status_pkg::*;
;
   logic              clock_i, rstn_i, read_i, write_i, irq_o;
   logic              conv_busy_i, conv_sleep_i, result_load_i;
   logic              set_done_i, waitrequest_o, conversion_done_pin_n_o;
   logic [ADDR_W-1:0] address_i;
   logic [31:0]       writedata_i, readdata_o, rd, r;
   logic [3:0]        byteenable_i, scan_mode_o;
   logic [1:0]        response_o, rsp, fn, ist, msk;
   logic [4:0]        result_chan_i, result_drained_i, fr, ld, dr, ch;
   logic              g, slp, sd, sn;
   int                fails, checked, seed;

   meas_adc_status_flags dut (.*);
   meas_host host (.clock_i(clock_i), .waitrequest_i(waitrequest_o),
      .readdata_i(readdata_o), .response_i(response_o),
      .address_o(address_i), .read_o(read_i), .write_o(write_i),
      .writedata_o(writedata_i));

   initial begin
      clock_i = 1'b0;
      forever #20 clock_i = !clock_i;
   end

   task automatic give_verdict();
      if (fails == 0 && checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   task automatic check(input string what, input logic [31:0] seen,
                        input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         fails++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic bus(input logic wr, input logic [5:0] a,
                      input logic [31:0] wd);
      bit ok;
      host.access(wr, a, wd, rd, rsp, ok);
      if (!ok) begin
         fails++;
         give_verdict();
      end
   endtask

   function automatic logic [31:0] stat_exp();
      return {16'h0, fn, slp, 1'b0, g, 4'h0, fr[4:2], 1'b0, fr[1:0], 1'b0};
   endfunction

   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      {rstn_i, conv_busy_i, conv_sleep_i, result_load_i, set_done_i} = 0;
      result_chan_i = 5'h00;
      result_drained_i = 5'h00;
      byteenable_i = 4'hf;
      {fails, checked, g, slp, fr, ist} = 0;
      seed = 41728;
      fn = PIN_FN_RESET;
      repeat (5) @(posedge clock_i);
      rstn_i <= 1'b1;
      bus(0, STATUS_ADDR, 0);
      check("status", rd, stat_exp());
      bus(0, 6'h3c, 32'h0000_ffff);
      check("unmapped", {rd[29:0], rsp}, 32'h2);
      bus(1, STATUS_ADDR, 32'hffff_ffff);
      fn = 2'h3;
      bus(0, STATUS_ADDR, 0);
      check("status", rd, stat_exp());
      bus(1, CONV_CTRL_ADDR, {28'h0, SCAN_PORT});
      @(negedge clock_i);
      check("scan", {28'h0, scan_mode_o}, {28'h0, SCAN_PORT});
      msk = 2'h1;
      bus(1, IRQ_MASK_ADDR, {30'h0, msk});
      fn = PIN_FN_DONE;
      bus(1, STATUS_ADDR, {16'h0, fn, 14'h0});
      // Random loads, drains and set ends; loads win over drains
      for (int i = 0; i < 60; i++) begin
         r  = $random(seed);
         ch = 5'h1 << (r[3:1] % 3'h5);
         ld = r[0] ? ch : 5'h00;
         sd = r[4] & r[5];
         dr = r[10:6] & r[15:11];
         sn = r[16] & !r[17];
         @(posedge clock_i);
         result_load_i    <= r[0];
         result_chan_i    <= ch;
         set_done_i       <= sd;
         result_drained_i <= dr;
         conv_sleep_i     <= r[16];
         conv_busy_i      <= r[17];
         @(posedge clock_i);
         result_load_i    <= 1'b0;
         set_done_i       <= 1'b0;
         result_drained_i <= 5'h00;
         fr  = (fr & ~dr) | ld;
         g   = (g | sd) && fr != 5'h00;
         ist = ist | {sn & !slp, sd};
         slp = sn;
         repeat (3) @(posedge clock_i);
         @(negedge clock_i);
         check("pin", 32'(conversion_done_pin_n_o), 32'(!g));
         check("irq", 32'(irq_o), 32'(|(ist & msk)));
         bus(0, STATUS_ADDR, 0);
         check("status", rd, stat_exp());
         bus(0, IRQ_STATUS_ADDR, 0);
         check("irq_status", rd, {30'h0, ist});
         if (r[18]) begin
            bus(1, IRQ_STATUS_ADDR, {30'h0, r[20:19]});
            ist = ist & ~r[20:19];
         end
         if (i == 30) begin
            msk = 2'h3;
            bus(1, IRQ_MASK_ADDR, {30'h0, msk});
         end
      end
      give_verdict();
   end
endmodule // meas_adc_status_flags_bench
